// ### bench/cg_wake_clear_and_reset_flags_tb.sv
// self-checking bench of the wake clear and reset flag registers
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
        num_errors++; \
        $display("Error at %0t: got %h expected %h", $time, (got), (exp)); \
    end end
module cg_wake_clear_and_reset_flags_tb;
    logic                            ref_clk, arst_n, watchdog_nmi, irq;
    logic                            s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic                            s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic                            s_axi_arvalid, s_axi_arready;
    logic                            s_axi_rvalid, s_axi_rready;
    logic [7:0]                      s_axi_awaddr, s_axi_araddr;
    logic [2:0]                      s_axi_awprot, s_axi_arprot;
    logic [31:0]                     s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]                      s_axi_wstrb;
    logic [1:0]                      s_axi_bresp, s_axi_rresp, resp;
    cgwr_pkg::cgwr_reset_event_type  reset_event;
    cgwr_pkg::cgwr_line_clear_type   line_clear, seen_clear;
    int                              num_errors, n_checks;
    cgwr_regs #(.ADDR_W(8)) dut (.*);
    // free running 100 MHz clock
    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;
    // one write, holding each channel until taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 20);
        seen_clear = line_clear;
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n >= 20) num_errors++;
    endtask
    // one read
    task automatic rdreg(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 20);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n >= 20) num_errors++;
    endtask
    // one-cycle event: bit0 watchdog nmi, bits 5..1 reset causes
    task automatic pulse(input logic [5:0] v);
        @(posedge ref_clk);
        watchdog_nmi <= v[0];
        reset_event <= v[5:1];
        @(posedge ref_clk);
        watchdog_nmi <= 1'b0;
        reset_event <= '0;
        @(posedge ref_clk);
    endtask
    // back-to-back clear codes 0..15, upper data bits ignored
    task automatic t_clear;
        for (int c = 0; c < 16; c++) begin
            wr(cgwr_pkg::OFS_REQ_CLEAR, 32'hffff_ffe0 | 32'(c));
            `CHK(seen_clear, {2{16'h1 << c}})
        end
        rdreg(cgwr_pkg::OFS_REQ_CLEAR);
        `CHK(rd, 32'h0)
        `CHK(line_clear, 32'h0)
    endtask
    // watchdog nmi flag set then cleared by reading
    task automatic t_nmi;
        rdreg(cgwr_pkg::OFS_NMI_FLAG);
        `CHK(rd, 32'h0)
        pulse(6'h01);
        rdreg(cgwr_pkg::OFS_NMI_FLAG);
        `CHK(rd, 32'h1)
        rdreg(cgwr_pkg::OFS_NMI_FLAG);
        `CHK(rd, 32'h0)
    endtask
    // interrupt raised, cleared by status read, then masked
    task automatic t_irq;
        wr(cgwr_pkg::OFS_IRQ_MASK, 32'h1);
        pulse(6'h01);
        `CHK(irq, 1'b1)
        rdreg(cgwr_pkg::OFS_IRQ_STATUS);
        `CHK(rd, 32'h1)
        @(posedge ref_clk);
        `CHK(irq, 1'b0)
        wr(cgwr_pkg::OFS_IRQ_MASK, 32'h0);
        pulse(6'h01);
        `CHK(irq, 1'b0)
        rdreg(cgwr_pkg::OFS_NMI_FLAG);
    endtask
    // reset cause flags accumulate until written to zero
    task automatic t_cause;
        logic [31:0] exp;
        rdreg(cgwr_pkg::OFS_CAUSE);
        `CHK(rd, 32'h1)
        wr(cgwr_pkg::OFS_CAUSE, 32'h0);
        exp = 32'h0;
        for (int i = 1; i < 6; i++) begin
            pulse(6'h1 << i);
            exp = exp | (32'h1 << i);
            rdreg(cgwr_pkg::OFS_CAUSE);
            `CHK(rd, exp)
        end
        wr(cgwr_pkg::OFS_CAUSE, 32'hffff_ffff);
        rdreg(cgwr_pkg::OFS_CAUSE);
        `CHK(rd, 32'h3e)
        wr(cgwr_pkg::OFS_CAUSE, 32'h0);
        rdreg(cgwr_pkg::OFS_CAUSE);
        `CHK(rd, 32'h0)
        rdreg(8'h14);
        `CHK({resp, rd}, {cgwr_pkg::RESP_SLVERR, 32'h0})
        wr(8'h14, 32'h1);
        `CHK(resp, cgwr_pkg::RESP_SLVERR)
    endtask
    // verdict and end of run
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, watchdog_nmi} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awprot, s_axi_arprot} = '0;
        s_axi_wstrb = 4'hf;
        reset_event = '0;
        num_errors = 0;
        n_checks = 0;
        arst_n = 1'b0;
        repeat (4) @(posedge ref_clk);
        arst_n <= 1'b1;
        t_clear;
        t_nmi;
        t_irq;
        t_cause;
        tally_and_finish;
    end
    // hang guard
    initial begin
        repeat (5000) @(posedge ref_clk);
        num_errors++;
        tally_and_finish;
    end
endmodule // cg_wake_clear_and_reset_flags_tb
`default_nettype wire

// ### bench/cgwr_regs_sva.sv
// checker for the wake clear and reset flag registers
`timescale 1ns/100ps
`default_nettype none
module cgwr_regs_sva #(
    parameter int unsigned ADDR_W = 8
) (
    input wire logic                              ref_clk,
    input wire logic                              arst_n,
    input wire logic                              s_axi_awvalid,
    input wire logic                              s_axi_awready,
    input wire logic [ADDR_W-1:0]                 s_axi_awaddr,
    input wire logic                              s_axi_wvalid,
    input wire logic                              s_axi_wready,
    input wire logic [cgwr_pkg::DATA_W-1:0]       s_axi_wdata,
    input wire logic [3:0]                        s_axi_wstrb,
    input wire logic                              s_axi_bvalid,
    input wire logic                              s_axi_bready,
    input wire logic                              s_axi_arvalid,
    input wire logic                              s_axi_arready,
    input wire logic [ADDR_W-1:0]                 s_axi_araddr,
    input wire logic                              s_axi_rvalid,
    input wire logic [cgwr_pkg::DATA_W-1:0]       s_axi_rdata,
    input wire logic                              watchdog_nmi,
    input wire cgwr_pkg::cgwr_reset_event_type    reset_event,
    input wire cgwr_pkg::cgwr_line_clear_type     line_clear
);
    localparam logic [ADDR_W-1:0] A_CLR = ADDR_W'(cgwr_pkg::OFS_REQ_CLEAR);
    localparam logic [ADDR_W-1:0] A_NMI = ADDR_W'(cgwr_pkg::OFS_NMI_FLAG);
    localparam logic [ADDR_W-1:0] A_CAU = ADDR_W'(cgwr_pkg::OFS_CAUSE);
    logic [ADDR_W-1:0] rd_addr, wr_addr;
    logic              nmi_seen, nmi_exp, pon_clr, pon_exp, wd0, cause_done;
    logic [4:0]        ev_seen, ev_exp;
    assign cause_done = s_axi_bvalid && s_axi_bready && wr_addr == A_CAU;
    // expected flag floor, tracked from events and cause writes
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            {rd_addr, wr_addr, nmi_seen, nmi_exp} <= '0;
            {pon_clr, pon_exp, wd0, ev_seen, ev_exp} <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) wr_addr <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) wd0 <= s_axi_wdata[0] | !s_axi_wstrb[0];
            if (s_axi_arvalid && s_axi_arready) begin
                rd_addr <= s_axi_araddr;
                nmi_exp <= nmi_seen;
                ev_exp  <= ev_seen;
                pon_exp <= !pon_clr;
            end
            if (s_axi_arvalid && s_axi_arready && s_axi_araddr == A_NMI) nmi_seen <= watchdog_nmi;
            else if (watchdog_nmi) nmi_seen <= 1'b1;
            ev_seen <= cause_done ? reset_event : (ev_seen | reset_event);
            if (cause_done && !wd0) pon_clr <= 1'b1;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    property p_clear_pulse;
        |line_clear.request |-> $onehot(line_clear.request) && $rose(s_axi_bvalid);
    endproperty
    a_clear_pulse: assert property (p_clear_pulse)
        else $error("clear pulse not one-hot with write response");
    property p_clear_edge;
        line_clear.edge_status == line_clear.request;
    endproperty
    a_clear_edge: assert property (p_clear_edge)
        else $error("edge status clear differs from request clear");
    property p_clear_once;
        |line_clear.request |=> line_clear.request == '0;
    endproperty
    a_clear_once: assert property (p_clear_once)
        else $error("clear pulse longer than one cycle");
    property p_clear_read;
        s_axi_rvalid && rd_addr == A_CLR |-> s_axi_rdata == '0;
    endproperty
    a_clear_read: assert property (p_clear_read)
        else $error("request clear register read not zero");
    property p_nmi_read;
        s_axi_rvalid && rd_addr == A_NMI |-> s_axi_rdata == {31'h0, nmi_exp};
    endproperty
    a_nmi_read: assert property (p_nmi_read)
        else $error("nmi flag read value wrong");
    property p_cause_ev;
        s_axi_rvalid && rd_addr == A_CAU |-> (s_axi_rdata[5:1] & ev_exp) == ev_exp;
    endproperty
    a_cause_ev: assert property (p_cause_ev)
        else $error("reset cause flag missing after event");
    property p_cause_pon;
        s_axi_rvalid && rd_addr == A_CAU |-> s_axi_rdata[0] == pon_exp;
    endproperty
    a_cause_pon: assert property (p_cause_pon)
        else $error("power-on cause flag wrong");
    property p_cause_upper;
        s_axi_rvalid && rd_addr == A_CAU |-> s_axi_rdata[31:6] == '0;
    endproperty
    a_cause_upper: assert property (p_cause_upper)
        else $error("reset cause upper bits not zero");
    // main scenarios reached
    c_clear: cover property (|line_clear.request);
    c_nmi: cover property (s_axi_rvalid && rd_addr == A_NMI && nmi_exp);
    c_cause: cover property (s_axi_rvalid && rd_addr == A_CAU && |ev_exp);
endmodule // cgwr_regs_sva
bind cgwr_regs cgwr_regs_sva #(.ADDR_W(ADDR_W)) u_sva (.*);
`default_nettype wire

// ### rtl/cgwr_pkg.sv
// constants and carrier types of the wake clear and reset flag registers
package cgwr_pkg;

    // data path widths
    localparam int unsigned DATA_W     = 32;
    localparam int unsigned LINE_COUNT = 16;
    localparam int unsigned CODE_W     = 5;
    localparam int unsigned CAUSE_W    = 6;
    localparam int unsigned OFS_W      = 8;

    // register byte offsets
    localparam logic [OFS_W-1:0] OFS_REQ_CLEAR  = 8'h00;
    localparam logic [OFS_W-1:0] OFS_NMI_FLAG   = 8'h04;
    localparam logic [OFS_W-1:0] OFS_CAUSE      = 8'h08;
    localparam logic [OFS_W-1:0] OFS_IRQ_STATUS = 8'h0c;
    localparam logic [OFS_W-1:0] OFS_IRQ_MASK   = 8'h10;

    // reset cause bit positions, also used by status and mask
    localparam int unsigned BIT_PON  = 0;
    localparam int unsigned BIT_PIN  = 1;
    localparam int unsigned BIT_WDT  = 2;
    localparam int unsigned BIT_VOLT = 3;
    localparam int unsigned BIT_DBG  = 4;
    localparam int unsigned BIT_FREQ = 5;
    // nmi flag position in its register and in the status register
    localparam int unsigned BIT_NMI  = 0;

    // reset values
    localparam logic [CAUSE_W-1:0] CAUSE_RESET = 6'h01;
    localparam logic [CAUSE_W-1:0] MASK_RESET  = 6'h00;

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // register selected by an address
    typedef enum logic [2:0] {
        SEL_REQ_CLEAR,
        SEL_NMI_FLAG,
        SEL_CAUSE,
        SEL_IRQ_STATUS,
        SEL_IRQ_MASK,
        SEL_NONE
    } cgwr_sel_type;

    // reset sources other than power-on
    typedef struct packed {
        logic freq_detect;
        logic debug_request;
        logic voltage_detect;
        logic watchdog;
        logic pin;
    } cgwr_reset_event_type;

    // per-line clear strobes towards the standby release logic
    typedef struct packed {
        logic [LINE_COUNT-1:0] request;
        logic [LINE_COUNT-1:0] edge_status;
    } cgwr_line_clear_type;

endpackage

// ### rtl/cgwr_regs.sv
// wake request clear, watchdog nmi flag and reset cause registers
//
// Function
// - code 0..15 clears that line's wake request
// - request clear also clears captured edge status
// - nmi bit0 shows watchdog nmi, rest zero
// - any read of nmi register clears it
// - cause bit5 set by frequency detector reset
// - cause bit4 set by cpu system reset request
// - cause bit3 set by voltage detector reset
// - cause bit2 set by watchdog reset
// - cause bit1 set by reset pin
// - only power-on initialises causes, bit0 one
// - power-on bit never set by other resets
// - cause flags accumulate, hardware never clears
// - cause bits 31..6 read zero
//
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module cgwr_regs #(
    parameter int unsigned ADDR_W = 8
) (
    input  wire logic                          ref_clk,
    input  wire logic                          arst_n,
    // axi4-lite write address
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [ADDR_W-1:0]             s_axi_awaddr,
    input  wire logic [2:0]                    s_axi_awprot,
    // axi4-lite write data
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    input  wire logic [cgwr_pkg::DATA_W-1:0]   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    // axi4-lite write response
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    output logic [1:0]                         s_axi_bresp,
    // axi4-lite read address
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    input  wire logic [ADDR_W-1:0]             s_axi_araddr,
    input  wire logic [2:0]                    s_axi_arprot,
    // axi4-lite read data
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    output logic [cgwr_pkg::DATA_W-1:0]        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    // event sources
    input  wire logic                          watchdog_nmi,
    input  wire cgwr_pkg::cgwr_reset_event_type reset_event,
    // clear strobes towards the standby release logic
    output cgwr_pkg::cgwr_line_clear_type      line_clear,
    // interrupt
    output logic                               irq
);

    // register map, one aligned word per register
    //   0x00 request clear, write only
    //        code in bits 4..0 selects one wake line
    //        codes 0..15 pulse that line for one cycle
    //        codes 16..31 are reserved, nothing happens
    //        the same pulse also drops the captured edge
    //        reads back zero, nothing is stored
    //   0x04 watchdog nmi flag
    //        bit 0 set while an nmi is pending
    //        any read returns the flag and clears it
    //        writes are ignored
    //   0x08 reset cause flags
    //        bit 0 power-on, bit 1 reset pin
    //        bit 2 watchdog, bit 3 voltage detector
    //        bit 4 cpu request, bit 5 frequency detector
    //        writing 0 clears a bit, writing 1 keeps it
    //        software can never set a bit
    //        bits 31..6 read zero
    //   0x0c interrupt status, read only
    //        nmi in bit 0, reset causes in bits 5..1
    //        a read clears every bit
    //   0x10 interrupt mask, same layout, 1 enables
    //   any other offset answers slverr, reads zero
    //
    // bus timing
    //   address and data captured in either order
    //   write performed one cycle after both are held
    //   bvalid and the clear strobe rise together
    //   read data registered one cycle after ar taken
    //   each channel refuses while its response waits
    //   one write and one read may overlap
    //
    // hazards and limits
    //   events in a clearing cycle win over the clear
    //   arst_n is power-on only; other chip resets
    //   arrive as events and never clear the causes
    //   strobe lanes 1..3 carry no field and are ignored
    //   protection bits are accepted and not checked
    //   event inputs are levels, every high cycle sets

    // register and bus state, except the interrupt status flags held in u_status
    typedef struct packed {
        logic                                aw_held;
        logic [ADDR_W-1:0]                   awaddr;
        logic                                w_held;
        logic [cgwr_pkg::DATA_W-1:0]         wdata;
        logic [3:0]                          wstrb;
        logic                                bvalid;
        logic [1:0]                          bresp;
        logic                                rvalid;
        logic [cgwr_pkg::DATA_W-1:0]         rdata;
        logic [1:0]                          rresp;
        logic                                nmi_flag;
        logic [cgwr_pkg::CAUSE_W-1:0]        cause;
        logic [cgwr_pkg::CAUSE_W-1:0]        mask;
        logic [cgwr_pkg::LINE_COUNT-1:0]     clear_pulse;
    } cgwr_state_type;

    cgwr_state_type state;
    cgwr_state_type next_state;

    // channel handshakes taken this cycle
    logic                         aw_take;
    logic                         w_take;
    logic                         ar_take;

    // write performed this cycle
    logic                         write_go;

    // interrupt status path
    logic                         status_read;
    logic [cgwr_pkg::CAUSE_W-1:0] status_set;
    logic [cgwr_pkg::CAUSE_W-1:0] status_flags;
    logic [cgwr_pkg::CAUSE_W-1:0] cause_set;

    // decoded registers of the held write and the offered read
    cgwr_pkg::cgwr_sel_type       wr_sel;
    cgwr_pkg::cgwr_sel_type       rd_sel;

    // map a byte address onto a register
    function automatic cgwr_pkg::cgwr_sel_type decode(
        input logic [ADDR_W-1:0] addr
    );
        cgwr_pkg::cgwr_sel_type sel;
        sel = cgwr_pkg::SEL_NONE;
        if (addr == ADDR_W'(cgwr_pkg::OFS_REQ_CLEAR)) begin
            sel = cgwr_pkg::SEL_REQ_CLEAR;
        end else if (addr == ADDR_W'(cgwr_pkg::OFS_NMI_FLAG)) begin
            sel = cgwr_pkg::SEL_NMI_FLAG;
        end else if (addr == ADDR_W'(cgwr_pkg::OFS_CAUSE)) begin
            sel = cgwr_pkg::SEL_CAUSE;
        end else if (addr == ADDR_W'(cgwr_pkg::OFS_IRQ_STATUS)) begin
            sel = cgwr_pkg::SEL_IRQ_STATUS;
        end else if (addr == ADDR_W'(cgwr_pkg::OFS_IRQ_MASK)) begin
            sel = cgwr_pkg::SEL_IRQ_MASK;
        end
        return sel;
    endfunction

    // widen a six bit field into a bus word, upper bits zero
    function automatic logic [cgwr_pkg::DATA_W-1:0] widen(
        input logic [cgwr_pkg::CAUSE_W-1:0] field
    );
        return {{(cgwr_pkg::DATA_W - cgwr_pkg::CAUSE_W){1'b0}}, field};
    endfunction

    // bus handshakes
    assign s_axi_awready = !state.aw_held && !state.bvalid;
    assign s_axi_wready  = !state.w_held && !state.bvalid;
    assign s_axi_arready = !state.rvalid;
    assign aw_take       = s_axi_awvalid && s_axi_awready;
    assign w_take        = s_axi_wvalid && s_axi_wready;
    assign ar_take       = s_axi_arvalid && s_axi_arready;
    assign write_go      = state.aw_held && state.w_held && !state.bvalid;
    assign wr_sel        = decode(state.awaddr);
    assign rd_sel        = decode(s_axi_araddr);
    assign status_read   = ar_take && (rd_sel == cgwr_pkg::SEL_IRQ_STATUS);

    // hardware events that set the reset cause flags
    always_comb begin
        cause_set                     = '0;
        cause_set[cgwr_pkg::BIT_FREQ] = reset_event.freq_detect;
        cause_set[cgwr_pkg::BIT_DBG]  = reset_event.debug_request;
        cause_set[cgwr_pkg::BIT_VOLT] = reset_event.voltage_detect;
        cause_set[cgwr_pkg::BIT_WDT]  = reset_event.watchdog;
        cause_set[cgwr_pkg::BIT_PIN]  = reset_event.pin;
        // power-on position stays zero here
    end

    // interrupt events: the nmi plus every reset cause except power-on
    always_comb begin
        status_set                    = cause_set;
        status_set[cgwr_pkg::BIT_NMI] = watchdog_nmi;
    end

    // next state of bus channels and registers
    always_comb begin
        next_state             = state;
        next_state.clear_pulse = '0; // strobe lasts one cycle

        // capture address and data in either order
        if (aw_take) begin
            next_state.aw_held = 1'b1;
            next_state.awaddr  = s_axi_awaddr;
        end
        if (w_take) begin
            next_state.w_held = 1'b1;
            next_state.wdata  = s_axi_wdata;
            next_state.wstrb  = s_axi_wstrb;
        end

        // response handshakes
        if (state.bvalid && s_axi_bready) begin
            next_state.bvalid = 1'b0;
        end
        if (state.rvalid && s_axi_rready) begin
            next_state.rvalid = 1'b0;
        end

        // perform a write once both halves are in
        if (write_go) begin
            next_state.aw_held = 1'b0;
            next_state.w_held  = 1'b0;
            next_state.bvalid  = 1'b1;
            next_state.bresp   = cgwr_pkg::RESP_OKAY;
            unique case (wr_sel)
                cgwr_pkg::SEL_REQ_CLEAR: begin
                    // top code bit set means reserved, no line
                    if (state.wstrb[0] && !state.wdata[cgwr_pkg::CODE_W-1]) begin
                        next_state.clear_pulse[
                            state.wdata[cgwr_pkg::CODE_W-2:0]] = 1'b1;
                    end
                end
                cgwr_pkg::SEL_NMI_FLAG: begin
                    // read-only, write ignored
                end
                cgwr_pkg::SEL_CAUSE: begin
                    if (state.wstrb[0]) begin
                        next_state.cause = state.cause
                            & state.wdata[cgwr_pkg::CAUSE_W-1:0];
                    end
                end
                cgwr_pkg::SEL_IRQ_STATUS: begin
                    // read-only, write ignored
                end
                cgwr_pkg::SEL_IRQ_MASK: begin
                    if (state.wstrb[0]) begin
                        next_state.mask = state.wdata[cgwr_pkg::CAUSE_W-1:0];
                    end
                end
                cgwr_pkg::SEL_NONE: begin
                    next_state.bresp = cgwr_pkg::RESP_SLVERR;
                end
            endcase
        end

        // take a read and latch its data
        if (ar_take) begin
            next_state.rvalid = 1'b1;
            next_state.rresp  = cgwr_pkg::RESP_OKAY;
            next_state.rdata  = '0;
            unique case (rd_sel)
                cgwr_pkg::SEL_REQ_CLEAR: begin
                    next_state.rdata = '0;
                end
                cgwr_pkg::SEL_NMI_FLAG: begin
                    next_state.rdata[cgwr_pkg::BIT_NMI] = state.nmi_flag;
                    next_state.nmi_flag = 1'b0;
                end
                cgwr_pkg::SEL_CAUSE: begin
                    next_state.rdata = widen(state.cause);
                end
                cgwr_pkg::SEL_IRQ_STATUS: begin
                    next_state.rdata = widen(status_flags);
                end
                cgwr_pkg::SEL_IRQ_MASK: begin
                    next_state.rdata = widen(state.mask);
                end
                cgwr_pkg::SEL_NONE: begin
                    next_state.rresp = cgwr_pkg::RESP_SLVERR;
                end
            endcase
        end

        // hardware sets win over read and write clears
        if (watchdog_nmi) begin
            next_state.nmi_flag = 1'b1;
        end
        next_state.cause = next_state.cause | cause_set;
    end

    // state register; arst_n is the power-on reset only
    // causes come up with only the power-on bit set,
    // the mask comes up closed so no interrupt follows
    // reset; the bus comes up idle and ready
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state       <= '0;
            state.cause <= cgwr_pkg::CAUSE_RESET;
            state.mask  <= cgwr_pkg::MASK_RESET;
        end else begin
            state <= next_state;
        end
    end

    // interrupt status flags
    // the status read clears them in the cycle the
    // read is taken; an event in that cycle survives
    cgwr_sticky_flags #(
        .WIDTH (cgwr_pkg::CAUSE_W)
    ) u_status (
        .ref_clk    (ref_clk),
        .arst_n     (arst_n),
        .set        (status_set),
        .read_clear (status_read),
        .mask       (state.mask),
        .flags      (status_flags),
        .irq        (irq)
    );

    // outputs from registers
    // both clear halves carry the same one-cycle pulse
    assign s_axi_bvalid           = state.bvalid;
    assign s_axi_bresp            = state.bresp;
    assign s_axi_rvalid           = state.rvalid;
    assign s_axi_rdata            = state.rdata;
    assign s_axi_rresp            = state.rresp;
    assign line_clear.request     = state.clear_pulse;
    assign line_clear.edge_status = state.clear_pulse;

endmodule // cgwr_regs
`default_nettype wire

// ### rtl/cgwr_sticky_flags.sv
// sticky event flags with clear on read, mask and level interrupt
`timescale 1ns/100ps
`default_nettype none
module cgwr_sticky_flags #(
    parameter int unsigned WIDTH = 6
) (
    input  wire logic             ref_clk,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] set,
    input  wire logic             read_clear,
    input  wire logic [WIDTH-1:0] mask,
    output logic      [WIDTH-1:0] flags,
    output logic                  irq
);

    typedef struct packed {
        logic [WIDTH-1:0] flags;
    } cgwr_flag_state_type;

    cgwr_flag_state_type state;
    cgwr_flag_state_type next_state;

    // an event in the clearing cycle survives the clear
    always_comb begin
        next_state = state;
        if (read_clear) begin
            next_state.flags = '0;
        end
        next_state.flags = next_state.flags | set;
    end

    // state register
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign flags = state.flags;
    assign irq   = |(state.flags & mask); // high while unmasked flag set

endmodule // cgwr_sticky_flags
`default_nettype wire
